// *** pkg/mcd_pkg.sv ***
// constants, opcodes and states shared by the opcode decoder core
package mcd_pkg;
	// widths
	localparam int PC_W = 11;
	localparam int DATA_W = 8;
	localparam int RAM_AW = 6;
	localparam int RAM_WORDS = 64;
	// instruction cycle framing: one strobe per 30 input clocks
	localparam int CYCLE_CLKS = 30;
	localparam int STROBE_HIGH_CLKS = 15;
	localparam int FETCH_PHASE = 2;
	// sampling window as hundredths of an instruction cycle
	localparam int SETUP_PCT = 20;
	localparam int HOLD_PCT = 10;
	localparam int SETUP_CLKS = (CYCLE_CLKS * SETUP_PCT) / 100;
	localparam int HOLD_CLKS = (CYCLE_CLKS * HOLD_PCT) / 100;
	localparam int WIN_OPEN = STROBE_HIGH_CLKS - SETUP_CLKS;
	localparam int WIN_CLOSE = STROBE_HIGH_CLKS + HOLD_CLKS;
	// last instruction cycle of a four-cycle conversion
	localparam logic [1:0] CONV_LAST = 2'h3;
	// reset values
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	// opcodes
	localparam logic [7:0] OP_MOV_AI = 8'h23;
	localparam logic [7:0] OP_XCH_IND = 8'h20;
	localparam logic [7:0] OP_XCH_REG = 8'h28;
	localparam logic [7:0] OP_SWAP_LOW_NIBBLE = 8'h30;
	localparam logic [7:0] OP_CONV_RD = 8'h80;
	localparam logic [7:0] OP_CARRY_CLEAR_OP = 8'h97;
	localparam logic [7:0] OP_ST_IND = 8'ha0;
	localparam logic [7:0] OP_LOOKUP = 8'ha3;
	localparam logic [7:0] OP_CARRY_INVERT_OP = 8'ha7;
	localparam logic [7:0] OP_ST_REG = 8'ha8;
	localparam logic [7:0] OP_IMM_IND = 8'hb0;
	localparam logic [7:0] OP_IMM_REG = 8'hb8;
	localparam logic [7:0] OP_LD_IND = 8'hf0;
	localparam logic [7:0] OP_LD_REG = 8'hf8;
	// sequencer states, one-hot
	typedef enum logic [1:0] {
		MCD_ST_FETCH = 2'b01,
		MCD_ST_SECOND = 2'b10
	} mcd_state_e;
endpackage

// *** design/mcd_core.sv ***
// instruction decode and sequencing core of a small 8-bit controller
`timescale 1ns/1ps
module mcd_core
	import mcd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// program memory, read data valid in the same clock
	output logic [PC_W-1:0] pm_addr,
	input wire logic [DATA_W-1:0] pm_data,
	// analog front end, already digitised sample per channel
	input wire logic [DATA_W-1:0] analog_input_zero,
	input wire logic [DATA_W-1:0] analog_input_one,
	input wire logic channel_select,
	// timing outputs
	output logic cycle_strobe,
	output logic sample_window,
	output logic conversion_done,
	// visible state
	output logic [DATA_W-1:0] acc,
	output logic carry,
	output logic [PC_W-1:0] pc,
	output logic port_designator_ok
);
	// true for opcodes that occupy two instruction cycles
	function automatic logic is_two_cycle(input logic [7:0] op);
		is_two_cycle = (op == OP_MOV_AI) || (op == OP_LOOKUP) || (op == OP_CONV_RD) ||
			(op[7:1] == OP_IMM_IND[7:1]) || (op[7:3] == OP_IMM_REG[7:3]);
	endfunction
	// on-chip ports 1,2 and expander ports 4 to 7
	function automatic logic port_ok(input logic [2:0] p);
		port_ok = (p == 3'h1) || (p == 3'h2) || (p[2] == 1'b1);
	endfunction

	// sequencer state
	mcd_state_e state_reg;
	mcd_state_e state_next;
	logic [4:0] phase_reg; // position within the instruction cycle
	logic [4:0] phase_next;
	logic [7:0] opcode_reg; // opcode of the instruction in flight
	logic [7:0] operand_reg; // second program byte
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pm_addr_reg;
	logic [DATA_W-1:0] acc_reg;
	logic carry_reg;
	logic strobe_reg;
	logic window_reg;
	// data memory: working registers live in the first eight words
	logic [DATA_W-1:0] ram [RAM_WORDS];
	// converter
	logic [1:0] conv_cnt_reg;
	logic [DATA_W-1:0] sample_reg;
	logic [DATA_W-1:0] result_reg;
	logic done_reg;

	// decode wires
	wire cycle_end = (phase_reg == 5'(CYCLE_CLKS - 1));
	wire fetch_edge = (phase_reg == 5'(FETCH_PHASE));
	wire two_cyc = is_two_cycle(opcode_reg);
	wire exec = cycle_end && ((state_reg == MCD_ST_SECOND) || !two_cyc);
	wire [RAM_AW-1:0] ptr_addr = ram[{5'h00, opcode_reg[0]}][RAM_AW-1:0];
	wire [RAM_AW-1:0] reg_addr = {3'h0, opcode_reg[2:0]};
	wire [DATA_W-1:0] ind_data = ram[ptr_addr];
	wire [DATA_W-1:0] reg_data = ram[reg_addr];
	wire is_st_ind = (opcode_reg[7:1] == OP_ST_IND[7:1]);
	wire is_ld_ind = (opcode_reg[7:1] == OP_LD_IND[7:1]);
	wire is_xch_ind = (opcode_reg[7:1] == OP_XCH_IND[7:1]);
	wire is_swap_low_nibble = (opcode_reg[7:1] == OP_SWAP_LOW_NIBBLE[7:1]);
	wire is_imm_ind = (opcode_reg[7:1] == OP_IMM_IND[7:1]);
	wire is_xch_reg = (opcode_reg[7:3] == OP_XCH_REG[7:3]);
	wire is_imm_reg = (opcode_reg[7:3] == OP_IMM_REG[7:3]);
	wire is_st_reg = (opcode_reg[7:3] == OP_ST_REG[7:3]);
	wire is_ld_reg = (opcode_reg[7:3] == OP_LD_REG[7:3]);
	// opcodes whose second cycle fetches an operand byte; the others must not step pc then
	wire two_byte = (opcode_reg == OP_MOV_AI) || is_imm_ind || is_imm_reg;
	// lookup stays inside the current 256-byte page
	wire [PC_W-1:0] lookup_addr = {pc_reg[PC_W-1:8], acc_reg};
	wire [DATA_W-1:0] sel_input = channel_select ? analog_input_one : analog_input_zero;

	// accumulator, carry and memory write results of the executing opcode
	logic [DATA_W-1:0] acc_next;
	logic carry_next;
	logic ram_we;
	logic [RAM_AW-1:0] ram_waddr;
	logic [DATA_W-1:0] ram_wdata;
	always_comb begin
		acc_next = acc_reg;
		carry_next = carry_reg;
		ram_we = 1'b0;
		ram_waddr = ptr_addr;
		ram_wdata = acc_reg;
		if (exec) begin
			if (opcode_reg == OP_MOV_AI) begin
				acc_next = operand_reg;
			end else if (opcode_reg == OP_LOOKUP) begin
				acc_next = operand_reg;
			end else if (opcode_reg == OP_CONV_RD) begin
				acc_next = result_reg;
			end else if (opcode_reg == OP_CARRY_CLEAR_OP) begin
				carry_next = 1'b0;
			end else if (opcode_reg == OP_CARRY_INVERT_OP) begin
				carry_next = !carry_reg;
			end else if (is_st_ind) begin
				ram_we = 1'b1;
			end else if (is_ld_ind) begin
				acc_next = ind_data;
			end else if (is_xch_ind) begin
				acc_next = ind_data;
				ram_we = 1'b1;
			end else if (is_swap_low_nibble) begin
				acc_next = {acc_reg[7:4], ind_data[3:0]};
				ram_wdata = {ind_data[7:4], acc_reg[3:0]};
				ram_we = 1'b1;
			end else if (is_imm_ind) begin
				ram_wdata = operand_reg;
				ram_we = 1'b1;
			end else if (is_xch_reg) begin
				acc_next = reg_data;
				ram_waddr = reg_addr;
				ram_we = 1'b1;
			end else if (is_imm_reg) begin
				ram_waddr = reg_addr;
				ram_wdata = operand_reg;
				ram_we = 1'b1;
			end else if (is_st_reg) begin
				ram_waddr = reg_addr;
				ram_we = 1'b1;
			end else if (is_ld_reg) begin
				acc_next = reg_data;
			end else begin
				acc_next = acc_reg; // unlisted opcodes act as no-ops
			end
		end
	end

	// phase counter wraps every instruction cycle
	assign phase_next = cycle_end ? 5'h00 : phase_reg + 5'h01;

	// next sequencer state: two-cycle opcodes spend one extra cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MCD_ST_FETCH: begin
				if (cycle_end && two_cyc) begin
					state_next = MCD_ST_SECOND;
				end
			end
			MCD_ST_SECOND: begin
				if (cycle_end) begin
					state_next = MCD_ST_FETCH;
				end
			end
			default: begin
				state_next = MCD_ST_FETCH;
			end
		endcase
	end

	// sequencer registers; reset forces the first fetch from zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= MCD_ST_FETCH;
			phase_reg <= 5'h00;
			pc_reg <= PC_RESET;
			acc_reg <= ACC_RESET;
			carry_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			acc_reg <= acc_next;
			carry_reg <= carry_next;
			// only opcode and operand bytes step pc; the lookup byte and the idle
			// second cycle of a conversion read must not skip the next opcode
			if (fetch_edge && (state_reg == MCD_ST_FETCH || two_byte)) begin
				pc_reg <= pc_reg + 11'h001;
			end
		end
	end

	// byte capture: opcode in the first cycle, operand in the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opcode_reg <= 8'h00;
			operand_reg <= 8'h00;
		end else if (fetch_edge && state_reg == MCD_ST_FETCH) begin
			opcode_reg <= pm_data;
		end else if (fetch_edge) begin
			operand_reg <= pm_data;
		end
	end

	// program address is set up at the start of each cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pm_addr_reg <= PC_RESET;
		end else if (phase_next == 5'h00) begin
			pm_addr_reg <= (state_next == MCD_ST_SECOND && opcode_reg == OP_LOOKUP) ? lookup_addr : pc_reg;
		end
	end

	// data memory write; no reset so it maps onto a plain array
	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram[ram_waddr] <= ram_wdata;
		end
	end

	// strobe and sampling window track the phase of the next clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strobe_reg <= 1'b0;
			window_reg <= 1'b0;
		end else begin
			strobe_reg <= (phase_next < 5'(STROBE_HIGH_CLKS));
			window_reg <= (phase_next >= 5'(WIN_OPEN)) && (phase_next < 5'(WIN_CLOSE));
		end
	end

	// converter: sample in cycle zero, result lands after cycle three
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_cnt_reg <= 2'h0;
			sample_reg <= 8'h00;
			result_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			done_reg <= cycle_end && (conv_cnt_reg == CONV_LAST);
			if (cycle_end) begin
				conv_cnt_reg <= conv_cnt_reg + 2'h1;
			end
			// input is held while the window is open, taken as it closes
			if (conv_cnt_reg == 2'h0 && phase_reg == 5'(WIN_CLOSE - 1)) begin
				sample_reg <= sel_input;
			end
			if (cycle_end && conv_cnt_reg == CONV_LAST) begin
				result_reg <= sample_reg;
			end
		end
	end

	// outputs
	assign pm_addr = pm_addr_reg;
	assign cycle_strobe = strobe_reg;
	assign sample_window = window_reg;
	assign conversion_done = done_reg;
	assign acc = acc_reg;
	assign carry = carry_reg;
	assign pc = pc_reg;
	assign port_designator_ok = port_ok(opcode_reg[2:0]);

	// checks
	// the first strobe after reset starts at phase 1, one clock short, so it is not timed
	a_strobe_period: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(cycle_strobe) && $past(rst_n, 2) |-> ##30 $rose(cycle_strobe)) else $error("strobe period wrong");
	// a strobe dropped by reset is not a real fall, so the edge after reset is skipped
	a_window_open: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(cycle_strobe) && $past(rst_n) |-> $past(sample_window, 6) && !$past(sample_window, 7))
		else $error("window opened at wrong time");
	a_window_close: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(cycle_strobe) && $past(rst_n) |-> sample_window ##2 sample_window ##1 !sample_window)
		else $error("window closed at wrong time");
	a_reset_state: assert property (@(posedge clk)
		!rst_n |=> pc == 11'h000 && !carry) else $error("reset did not clear state");
	a_carry_clear: assert property (@(posedge clk) disable iff (!rst_n)
		exec && opcode_reg == OP_CARRY_CLEAR_OP |=> !carry) else $error("carry not cleared");
	a_carry_invert: assert property (@(posedge clk) disable iff (!rst_n)
		exec && opcode_reg == OP_CARRY_INVERT_OP |=> carry != $past(carry)) else $error("carry not inverted");
	a_imm_acc_load: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == MCD_ST_FETCH && cycle_end && opcode_reg == OP_MOV_AI
		|=> state_reg == MCD_ST_SECOND ##30 acc == operand_reg) else $error("immediate load wrong");
	a_reg_swap: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_xch_reg |=> acc == $past(reg_data) && reg_data == $past(acc))
		else $error("register swap wrong");
	a_conv_spacing: assert property (@(posedge clk) disable iff (!rst_n)
		conversion_done |-> ##120 conversion_done) else $error("conversion not four cycles");
	// data moves land where the opcode says
	a_imm_mem_store: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_imm_ind |=> ram[$past(ptr_addr)] == $past(operand_reg))
		else $error("immediate store to memory wrong");
	a_imm_reg_load: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_imm_reg |=> reg_data == $past(operand_reg))
		else $error("immediate load to register wrong");
	a_acc_store: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_st_ind |=> ram[$past(ptr_addr)] == $past(acc))
		else $error("accumulator store wrong");
	a_ind_load: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_ld_ind |=> acc == $past(ind_data))
		else $error("indirect load wrong");
	a_ind_swap: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_xch_ind |=> acc == $past(ind_data) && ram[$past(ptr_addr)] == $past(acc))
		else $error("indirect swap wrong");
	a_nibble_swap: assert property (@(posedge clk) disable iff (!rst_n)
		exec && is_swap_low_nibble |=> acc[7:4] == $past(acc[7:4]) && acc[3:0] == $past(ind_data[3:0])
		&& ram[$past(ptr_addr)][3:0] == $past(acc[3:0]))
		else $error("nibble swap wrong");
	// table lookup stays in the current page
	a_lookup_addr: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == MCD_ST_SECOND && opcode_reg == OP_LOOKUP |-> pm_addr == {pc[PC_W-1:8], acc})
		else $error("lookup address wrong");
	// byte sequencing and program counter stepping
	a_pc_hold: assert property (@(posedge clk) disable iff (!rst_n)
		fetch_edge && state_reg == MCD_ST_SECOND && !two_byte |=> $stable(pc))
		else $error("pc stepped in a one-byte second cycle");
	a_operand_fetch: assert property (@(posedge clk) disable iff (!rst_n)
		fetch_edge && state_reg == MCD_ST_SECOND |=> operand_reg == $past(pm_data))
		else $error("operand byte not captured");
	a_pc_step: assert property (@(posedge clk) disable iff (!rst_n)
		fetch_edge && state_reg == MCD_ST_FETCH |=> pc == $past(pc) + 11'h001)
		else $error("pc did not step on opcode fetch");
	// port field decode
	a_port_decode: assert property (@(posedge clk) disable iff (!rst_n)
		port_designator_ok == (opcode_reg[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7}))
		else $error("port designator decode wrong");
	// converter pulse and reset values
	a_done_width: assert property (@(posedge clk) disable iff (!rst_n)
		conversion_done |=> !conversion_done)
		else $error("done pulse too long");
	a_reset_outputs: assert property (@(posedge clk)
		!rst_n |=> acc == 8'h00 && pm_addr == 11'h000 && !cycle_strobe)
		else $error("reset did not clear outputs");
	// window opens and closes around the strobe fall
	a_window_span: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(sample_window) |-> ##6 $fell(cycle_strobe) ##3 $fell(sample_window))
		else $error("window span wrong");
endmodule

// *** sim/mcd_prog_mem.sv ***
// program memory model feeding instruction bytes to the decoder
`timescale 1ns/1ps
module mcd_prog_mem
	import mcd_pkg::*;
(
	// fetch side
	input wire logic [PC_W-1:0] pm_addr,
	output logic [DATA_W-1:0] pm_data
);
	// full eleven-bit space, loaded by the bench before reset ends
	logic [DATA_W-1:0] mem [0:(1<<PC_W)-1];
	// read is combinational, so the byte is settled long before phase 2
	assign pm_data = mem[pm_addr];
endmodule

// *** sim/tb.sv ***
// self-checking bench for the opcode decoder core
`timescale 1ns/1ps
module tb;
	import mcd_pkg::*;
	// one program step: opcode, operand, bytes, cycles, repeats, channel, expected acc and carry
	typedef struct {logic [7:0] op; logic [7:0] imm; int nb; int cy; int n; logic ch; logic [7:0] a; logic c;} mcd_row_s;
	logic clk, rst_n, channel_select, cycle_strobe, sample_window, conversion_done, carry, port_designator_ok;
	logic [PC_W-1:0] pm_addr, pc;
	logic [DATA_W-1:0] pm_data, analog_input_zero, analog_input_one, acc;
	int n_fail, comparisons, p;
	time t [0:4];
	// program and its expected results, in execution order
	mcd_row_s rows [] = '{
		'{8'h23, 8'h5a, 2, 2, 1, 0, 8'h5a, 0}, '{8'hb8, 8'h3c, 2, 2, 1, 0, 8'h5a, 0},
		'{8'hbf, 8'ha5, 2, 2, 1, 0, 8'h5a, 0}, '{8'hb0, 8'h77, 2, 2, 1, 0, 8'h5a, 0},
		'{8'hf0, 8'h00, 1, 1, 1, 0, 8'h77, 0}, '{8'h2f, 8'h00, 1, 1, 1, 0, 8'ha5, 0},
		'{8'h20, 8'h00, 1, 1, 1, 0, 8'h77, 0}, '{8'h30, 8'h00, 1, 1, 1, 0, 8'h75, 0},
		'{8'hf0, 8'h00, 1, 1, 1, 0, 8'ha7, 0}, '{8'h23, 8'he1, 2, 2, 1, 0, 8'he1, 0},
		'{8'ha0, 8'h00, 1, 1, 1, 0, 8'he1, 0}, '{8'h23, 8'h00, 2, 2, 1, 0, 8'h00, 0},
		'{8'hb9, 8'h3c, 2, 2, 1, 0, 8'h00, 0}, '{8'hf1, 8'h00, 1, 1, 1, 0, 8'he1, 0},
		'{8'ha7, 8'h00, 1, 1, 1, 0, 8'he1, 1}, '{8'h97, 8'h00, 1, 1, 1, 0, 8'he1, 0},
		'{8'ha7, 8'h00, 1, 1, 1, 0, 8'he1, 1}, '{8'ha7, 8'h00, 1, 1, 1, 0, 8'he1, 0},
		'{8'ha7, 8'h00, 1, 1, 1, 0, 8'he1, 1}, '{8'h23, 8'hf0, 2, 2, 1, 0, 8'hf0, 1},
		'{8'ha3, 8'h00, 1, 2, 1, 0, 8'h3e, 1}, '{8'h2f, 8'h00, 1, 1, 1, 0, 8'h77, 1},
		'{8'h80, 8'h00, 1, 2, 1, 0, 8'hc3, 1}, '{8'h00, 8'h00, 1, 1, 12, 1, 8'hc3, 1},
		'{8'h80, 8'h00, 1, 2, 1, 1, 8'h4b, 1}};

	mcd_core mcd_core_inst (.clk, .rst_n, .pm_addr, .pm_data, .analog_input_zero, .analog_input_one,
		.channel_select, .cycle_strobe, .sample_window, .conversion_done, .acc, .carry, .pc, .port_designator_ok);
	mcd_prog_mem mcd_prog_mem_inst (.pm_addr, .pm_data);

	// compare and count; unknowns never match
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// verdict and end of run
	task results;
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// 4 ns clock
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// watchdog, well beyond the expected run of under two thousand clocks
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("mismatch %0t watchdog expired", $time);
		results;
	end

	// main sequence
	initial begin
		rst_n = 0;
		channel_select = 0;
		analog_input_zero = 8'hc3;
		analog_input_one = 8'h4b;
		foreach (mcd_prog_mem_inst.mem[i]) mcd_prog_mem_inst.mem[i] = 8'h00;
		mcd_prog_mem_inst.mem[8'hf0] = 8'h3e;
		// lay the rows out as program bytes from address zero
		p = 0;
		foreach (rows[i]) for (int k = 0; k < rows[i].n; k++) begin
			mcd_prog_mem_inst.mem[p] = rows[i].op;
			p++;
			if (rows[i].nb == 2) begin
				mcd_prog_mem_inst.mem[p] = rows[i].imm;
				p++;
			end
		end
		repeat (16) @(negedge clk);
		rst_n = 1;
		@(posedge cycle_strobe);
		p = 0;
		// each row is judged at the strobe rise after its last cycle
		foreach (rows[i]) begin
			channel_select = rows[i].ch;
			repeat (rows[i].n * rows[i].cy) @(posedge cycle_strobe);
			@(negedge clk);
			chk(acc, rows[i].a, "acc");
			chk(carry, rows[i].c, "carry");
			chk(port_designator_ok, rows[i].op[2:0] inside {1, 2, [4:7]}, "port");
			p += rows[i].n * rows[i].nb;
			chk(pc, p, "pc");
		end
		// strobe and window edges within one instruction cycle
		@(posedge cycle_strobe) t[0] = $time;
		@(posedge sample_window) t[1] = $time;
		@(negedge cycle_strobe) t[2] = $time;
		@(negedge sample_window) t[3] = $time;
		@(posedge cycle_strobe) t[4] = $time;
		chk(32'(t[4] - t[0]), 30 * 4, "period");
		chk(32'(t[2] - t[0]), STROBE_HIGH_CLKS * 4, "strobe high");
		chk(32'(t[2] - t[1]), 6 * 4, "window open");
		chk(32'(t[3] - t[2]), 3 * 4, "window close");
		// one-clock done pulse every four instruction cycles
		@(posedge conversion_done) t[0] = $time;
		@(negedge clk);
		chk(conversion_done, 1, "done high");
		@(negedge clk);
		chk(conversion_done, 0, "done width");
		@(posedge conversion_done) t[1] = $time;
		chk(32'(t[1] - t[0]), 4 * 30 * 4, "done period");
		// reset in mid-run with acc and carry both non-zero
		@(negedge clk);
		rst_n = 0;
		@(negedge clk);
		chk({pc, pm_addr, acc, carry, cycle_strobe}, 0, "reset state");
		rst_n = 1;
		@(negedge clk);
		chk(cycle_strobe, 1, "first strobe");
		chk(pm_addr, 0, "first fetch");
		results;
	end
endmodule
